// file: src/rtcwd_core.sv
/*
  Watchdog, square-wave, frequency-test, reset supervision and calibrated
  divider chain of a serial real-time clock, behind a simple register port.
  Assumes the serial front end turns bus cycles into one-cycle read and write
  strobes, and that the pin pads resolve the open-drain outputs.
*/
`timescale 1ns/10ps
module rtcwd_core
  import rtcwd_pkg::*;
#(
  parameter int SLOW_FILT = SLOW_FILT_CYC,  // Slow reset input glitch filter
  parameter int REC_DEF   = REC_DEF_CYC,    // Recovery with select 0, stop 1
  parameter int REC_SLOW  = REC_SLOW_CYC,   // Recovery with select 0, stop 0
  parameter int REC_FAST  = REC_FAST_CYC    // Recovery with select 1
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] regAddr,        // Register offset
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,       // One-cycle write strobe
  input  wire logic       regRead,        // One-cycle read strobe
  output logic      [7:0] regRdData,      // Valid the cycle after regRead
  input  wire logic       oscIn,          // 32,768 Hz oscillator level
  input  wire logic       supplyOk,       // Supply above power-fail threshold
  input  wire logic       wdKickIn,
  input  wire logic       fastRstInN,
  input  wire logic       slowRstInN,
  input  wire logic       alarmIrqReq,    // Pending alarm from alarm logic
  input  wire logic       irqPinIn,
  output logic            irqPinOut,
  output logic            irqPinOeN,      // Low while pin pulled low
  input  wire logic       rstPinIn,
  output logic            rstPinOut,
  output logic            rstPinOeN,      // Low while reset asserted
  output logic            sqwPin,
  output logic            secondTick      // Calibrated one-second pulse
);

  localparam int RW = 24;  // Recovery and filter counter width

  // Parameters the counters cannot hold are refused
  if (SLOW_FILT < 1 || SLOW_FILT >= (1 << RW) || REC_DEF < 1 || REC_DEF >= (1 << RW) ||
      REC_SLOW < 1 || REC_SLOW >= (1 << RW) || REC_FAST < 1 || REC_FAST >= (1 << RW)) begin : g_chk
    $error("rtcwd_core: timing parameter out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Resolution step in oscillator cycles
  function automatic logic [21:0] wdStep(input logic [1:0] res);
    unique case (res)
      2'b00: wdStep = 22'(WD_STEP_16TH);
      2'b01: wdStep = 22'(WD_STEP_QUART);
      2'b10: wdStep = 22'(WD_STEP_ONE);
      2'b11: wdStep = 22'(WD_STEP_FOUR);
    endcase
  endfunction

  // Recovery length from select and stop bits
  function automatic logic [RW-1:0] recLoad(input logic sel, input logic stp);
    recLoad = sel ? RW'(REC_FAST) : (stp ? RW'(REC_DEF) : RW'(REC_SLOW));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  logic [7:0]    secReg;        // Seconds register, stop bit on top
  logic [7:0]    dayReg;        // Day register, recovery select on top
  logic [7:0]    ctrlReg;       // Output, test, sign, calibration
  logic [7:0]    wdReg;         // Steering, multiplier, resolution
  logic [7:0]    almReg;        // Alarm enables and alarm month
  logic [3:0]    sqwSel;        // Square-wave rate select
  logic          wdFlag;        // Watchdog expired flag
  logic          wdIrq;         // Timeout latched onto interrupt pin
  logic          wdDone;        // Timed out, waits for a register write
  logic          wdPulse;       // Reset pulse from watchdog in progress
  logic [21:0]   wdCount;       // Oscillator cycles to timeout
  logic [1:0]    kickSync;      // Kick input synchroniser
  logic          kickPrev;
  logic [1:0]    rstSync [2];   // Reset input synchronisers
  logic [RW-1:0] filtCnt [2];   // Low-time counters of reset inputs
  logic [RW-1:0] recCount;      // Remaining recovery cycles
  logic          oscPrev;
  logic [14:0]   rawDiv;        // Uncalibrated divider
  logic [15:0]   secCount;      // Calibrated second counter
  logic [5:0]    secIdx;        // Second within minute
  logic [5:0]    minIdx;        // Minute within calibration cycle

  ////////////////////////////////////////////////////////////////////////////
  // Decoding

  wire          powerDown = !supplyOk;
  wire          oscTick   = oscIn && !oscPrev;
  wire          isWrite   = regWrite && !powerDown;
  wire          wrWdog    = isWrite && regAddr == OFS_WDOG;
  wire          rdFlags   = regRead && regAddr == OFS_FLAGS;
  wire [4:0]    wdMult    = wdReg[6:2];
  wire          wdSteer   = wdReg[BIT_WDSTEER];
  wire          wdRun     = wdMult != 5'h00 && !wdDone;
  // A register write loads the period of the byte being written, not the old one
  wire [7:0]    wdLoad    = wrWdog ? regWrData : wdReg;
  wire [21:0]   wdPeriod  = 22'(wdLoad[6:2] * wdStep(wdLoad[1:0]));
  wire          kickEdge  = kickSync[1] != kickPrev;
  wire          wdRestart = kickEdge || wrWdog;
  wire          wdExpire  = wdRun && !powerDown && !wdRestart && oscTick && wdCount == 22'h000001;
  wire          wdRstStart = wdExpire && wdSteer;
  wire          extLow [2];
  wire [RW-1:0] filtTarget [2];
  wire          rstCause  = powerDown || extLow[0] || extLow[1] || wdRstStart;
  wire          wdEnd     = wdPulse && !rstCause && recCount == RW'(1);
  wire          ftOn      = ctrlReg[BIT_FTEST];
  wire          afeOn     = almReg[BIT_AFE];
  wire          ftSel     = !secReg[BIT_STOP] && ftOn && !afeOn && (wdSteer || wdReg == 8'h00);
  wire          plainOut  = !ftOn && !afeOn && wdReg == 8'h00;
  wire [4:0]    calMag    = ctrlReg[4:0];
  wire          calPos    = ctrlReg[BIT_CALSIGN];
  wire          calSec    = secIdx == 6'h00 && minIdx < 6'(CAL_ELIG_MIN) && minIdx < {calMag, 1'b0};
  wire [15:0]   secTerm   = !calSec ? 16'(OSC_PER_SEC) :
                            (calPos ? 16'(OSC_PER_SEC - CAL_SHORT_OSC) : 16'(OSC_PER_SEC + CAL_LONG_OSC));
  wire          sqwRaw    = sqwSel == 4'h1 ? oscIn : rawDiv[4'(sqwSel - 4'h1)];

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and reset-input filters

  // Kick input synchroniser; second stage feeds the edge detector
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      kickSync <= 2'b00;
      kickPrev <= 1'b0;
    end else begin
      kickSync <= {kickSync[0], wdKickIn};
      kickPrev <= kickSync[1];
    end
  end

  assign filtTarget[0] = RW'(FAST_FILT_CYC);
  assign filtTarget[1] = RW'(SLOW_FILT);

  // Each reset input must stay low for its full filter time to count
  for (genvar i = 0; i < 2; i++) begin : g_filt
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        rstSync[i] <= 2'b11;
        filtCnt[i] <= '0;
      end else begin
        rstSync[i] <= {rstSync[i][0], (i == 0) ? fastRstInN : slowRstInN};
        if (rstSync[i][1])
          filtCnt[i] <= '0;
        else if (filtCnt[i] != filtTarget[i])
          filtCnt[i] <= filtCnt[i] + RW'(1);
      end
    end
    assign extLow[i] = filtCnt[i] == filtTarget[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider chain and calibration

  // Raw divider runs free so the test rate ignores calibration
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      oscPrev <= 1'b0;
      rawDiv  <= '0;
    end else begin
      oscPrev <= oscIn;
      if (oscTick)
        rawDiv <= rawDiv + 15'h0001;
    end
  end

  // Adjusted second: shortened or stretched by whole oscillator cycles,
  // which equals splitting or blanking at the divide-by-256 stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      secCount   <= '0;
      secIdx     <= '0;
      minIdx     <= '0;
      secondTick <= 1'b0;
    end else begin
      secondTick <= 1'b0;
      if (oscTick) begin
        if (secCount >= secTerm - 16'h0001) begin
          secCount   <= '0;
          secondTick <= 1'b1;
          if (secIdx == 6'(SEC_PER_MIN - 1)) begin
            secIdx <= '0;
            minIdx <= 6'(minIdx + 6'h01);  // Wraps after 64 minutes
          end else begin
            secIdx <= secIdx + 6'h01;
          end
        end else begin
          secCount <= secCount + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog

  // Down-counter on oscillator cycles; halts after a timeout until rewritten
  always_ff @(posedge clk) begin
    if (sys_rst || powerDown) begin
      wdCount <= '0;
      wdDone  <= 1'b0;
      wdIrq   <= 1'b0;
    end else begin
      if (wdRestart)
        wdCount <= wdPeriod;
      else if (wdRun && oscTick)
        wdCount <= wdCount - 22'h000001;
      if (wrWdog)
        wdDone <= 1'b0;
      else if (wdExpire)
        wdDone <= 1'b1;
      if (wrWdog && regWrData == 8'h00)
        wdIrq <= 1'b0;
      else if (wdExpire && !wdSteer)
        wdIrq <= 1'b1;
    end
  end

  // Expired flag: a timeout in the clearing read's cycle still sets it
  always_ff @(posedge clk) begin
    if (sys_rst)
      wdFlag <= 1'b0;
    else if (wdExpire)
      wdFlag <= 1'b1;
    else if (rdFlags)
      wdFlag <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset output and recovery

  // Counter reloads while any cause holds; release after it drains
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      recCount  <= RW'(REC_DEF);  // Power-on reset pulse with default timing
      wdPulse   <= 1'b0;
      rstPinOeN <= 1'b0;
    end else begin
      if (rstCause)
        recCount <= recLoad(dayReg[BIT_RECSEL], secReg[BIT_STOP]);
      else if (recCount != '0)
        recCount <= recCount - RW'(1);
      if (wdRstStart)
        wdPulse <= 1'b1;
      else if (wdEnd || powerDown)
        wdPulse <= 1'b0;
      rstPinOeN <= !(rstCause || recCount > RW'(1));
    end
  end

  assign rstPinOut = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  // Power-down and the end of a watchdog reset override host writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      secReg  <= RST_SECONDS;
      dayReg  <= RST_DAY;
      ctrlReg <= RST_CONTROL;
      wdReg   <= RST_WDOG;
      almReg  <= RST_ALMMON;
      sqwSel  <= RST_SQWSEL;
    end else if (powerDown) begin
      wdReg               <= 8'h00;
      ctrlReg[BIT_FTEST]  <= 1'b0;
      almReg[BIT_AFE]     <= 1'b0;
      almReg[BIT_SQUARE_WAVE_OUTPUT_ENABLE]    <= 1'b0;
      almReg[BIT_ABE]     <= 1'b0;
    end else if (wdEnd) begin
      wdReg               <= 8'h00;
      ctrlReg[BIT_FTEST]  <= 1'b0;
      almReg[BIT_AFE]     <= 1'b0;
      almReg[BIT_SQUARE_WAVE_OUTPUT_ENABLE]    <= 1'b0;
      almReg[BIT_ABE]     <= 1'b0;
    end else if (isWrite) begin
      if (regAddr == OFS_SECONDS) secReg  <= regWrData;
      if (regAddr == OFS_DAY)     dayReg  <= regWrData;
      if (regAddr == OFS_CONTROL) ctrlReg <= regWrData;
      if (regAddr == OFS_WDOG)    wdReg   <= regWrData;
      if (regAddr == OFS_ALMMON)  almReg  <= regWrData;
      if (regAddr == OFS_SQWSEL)  sqwSel  <= regWrData[7:4];
    end
  end

  // Read data registered; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (sys_rst)
      regRdData <= 8'h00;
    else if (regRead) begin
      unique case (regAddr)
        OFS_SECONDS: regRdData <= secReg;
        OFS_DAY:     regRdData <= dayReg;
        OFS_CONTROL: regRdData <= ctrlReg;
        OFS_WDOG:    regRdData <= wdReg;
        OFS_ALMMON:  regRdData <= almReg;
        OFS_FLAGS:   regRdData <= {wdFlag, 7'h00};
        OFS_SQWSEL:  regRdData <= {sqwSel, 4'h0};
        default:     regRdData <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pins

  // Interrupt/test pin priority: watchdog, alarm, test tone, plain output
  wire irqLow = wdIrq ? 1'b1 :
                ftSel ? !rawDiv[FTEST_DIV_BIT] :
                afeOn ? alarmIrqReq :
                plainOut ? !ctrlReg[BIT_OUT] : 1'b0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqPinOeN <= 1'b1;
      sqwPin    <= 1'b0;
    end else begin
      irqPinOeN <= !irqLow;
      sqwPin    <= almReg[BIT_SQUARE_WAVE_OUTPUT_ENABLE] && sqwSel != 4'h0 && sqwRaw;
    end
  end

  assign irqPinOut = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  chk_wdf_read_clear: assert property (@(posedge clk) disable iff (sys_rst)
    rdFlags && !wdExpire |=> !wdFlag) else $error("flag not cleared by read");
  chk_wdf_set: assert property (@(posedge clk) disable iff (sys_rst)
    wdExpire |=> wdFlag && wdDone) else $error("timeout did not set flag");
  chk_irq_wd_low: assert property (@(posedge clk) disable iff (sys_rst)
    wdIrq |=> !irqPinOeN) else $error("watchdog interrupt not on pin");
  chk_rst_wd_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    wdRstStart |=> !rstPinOeN [*8]) else $error("watchdog reset pulse too short");
  chk_wd_end_clear: assert property (@(posedge clk) disable iff (sys_rst)
    wdEnd && !powerDown |=> wdReg == 8'h00 && !ftOn && !almReg[BIT_SQUARE_WAVE_OUTPUT_ENABLE] && !afeOn)
    else $error("bits not cleared after watchdog reset");
  chk_kick_restart: assert property (@(posedge clk) disable iff (sys_rst)
    kickEdge && !powerDown |=> wdCount == $past(wdPeriod)) else $error("kick did not restart");
  chk_irq_release: assert property (@(posedge clk) disable iff (sys_rst)
    wrWdog && regWrData == 8'h00 |=> !wdIrq && wdReg == 8'h00) else $error("zero write kept pin");
  chk_pdown_clear: assert property (@(posedge clk) disable iff (sys_rst)
    powerDown |=> !ftOn && wdReg == 8'h00 && !rstPinOeN) else $error("power-down state wrong");
  chk_sqw_off: assert property (@(posedge clk) disable iff (sys_rst)
    !almReg[BIT_SQUARE_WAVE_OUTPUT_ENABLE] |=> !sqwPin) else $error("square wave without enable");
  chk_ft_tone: assert property (@(posedge clk) disable iff (sys_rst)
    ftSel && !wdIrq |=> irqPinOeN == $past(rawDiv[FTEST_DIV_BIT])) else $error("test tone wrong");

  cov_wd_irq:   cover property (@(posedge clk) disable iff (sys_rst) wdExpire && !wdSteer);
  cov_wd_reset: cover property (@(posedge clk) disable iff (sys_rst) wdEnd);
  cov_slow_rst: cover property (@(posedge clk) disable iff (sys_rst) extLow[1] ##1 !extLow[1]);
  cov_cal_sec:  cover property (@(posedge clk) disable iff (sys_rst) calSec && secondTick);

endmodule

// file: src/rtcwd_pkg.sv
/*
  Constants for the supervisory and timing-output block of a serial real-time
  clock: register offsets, field positions, reset values and timing counts.
  Assumes a 100 MHz system clock and a 32,768 Hz oscillator level sampled on it.
*/
package rtcwd_pkg;

  // Register offsets
  localparam logic [7:0] OFS_SECONDS = 8'h01;
  localparam logic [7:0] OFS_DAY     = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_WDOG    = 8'h09;
  localparam logic [7:0] OFS_ALMMON  = 8'h0A;
  localparam logic [7:0] OFS_FLAGS   = 8'h0F;
  localparam logic [7:0] OFS_SQWSEL  = 8'h13;

  // Field positions
  localparam int BIT_STOP    = 7;  // Seconds register
  localparam int BIT_RECSEL  = 7;  // Day register
  localparam int BIT_OUT     = 7;  // Control register
  localparam int BIT_FTEST   = 6;
  localparam int BIT_CALSIGN = 5;
  localparam int BIT_WDSTEER = 7;  // Watchdog register
  localparam int BIT_AFE     = 7;  // Alarm month register
  localparam int BIT_SQUARE_WAVE_OUTPUT_ENABLE    = 6;
  localparam int BIT_ABE     = 5;
  localparam int BIT_WDFLAG  = 7;  // Flags register

  // Reset values
  localparam logic [7:0] RST_SECONDS = 8'h80;  // Stop set
  localparam logic [7:0] RST_DAY     = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h80;  // Output bit set
  localparam logic [7:0] RST_WDOG    = 8'h00;
  localparam logic [7:0] RST_ALMMON  = 8'h00;
  localparam logic [3:0] RST_SQWSEL  = 4'h0;

  // Oscillator divider chain, in oscillator cycles
  localparam int OSC_PER_SEC    = 32768;
  localparam int WD_STEP_16TH   = OSC_PER_SEC / 16;
  localparam int WD_STEP_QUART  = OSC_PER_SEC / 4;
  localparam int WD_STEP_ONE    = OSC_PER_SEC;
  localparam int WD_STEP_FOUR   = OSC_PER_SEC * 4;
  localparam int CAL_SHORT_OSC  = 128;
  localparam int CAL_LONG_OSC   = 256;
  localparam int SEC_PER_MIN    = 60;
  localparam int CAL_CYCLE_MIN  = 64;
  localparam int CAL_ELIG_MIN   = 62;
  localparam int FTEST_DIV_BIT  = 5;   // Divider bit toggling at 512 Hz

  // Timing in system clocks
  localparam int CLK_PERIOD_NS   = 10;
  localparam int FAST_FILT_NS    = 50;
  localparam int SLOW_FILT_MS    = 20;
  localparam int REC_DEF_MS      = 40;
  localparam int REC_SLOW_MS     = 96;
  localparam int REC_FAST_US     = 50;
  localparam int FAST_FILT_CYC   = (FAST_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOW_FILT_CYC   = SLOW_FILT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int REC_DEF_CYC     = REC_DEF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int REC_SLOW_CYC    = REC_SLOW_MS * 1000000 / CLK_PERIOD_NS;
  localparam int REC_FAST_CYC    = REC_FAST_US * 1000 / CLK_PERIOD_NS;

endpackage

// file: tb/rtcwd_host_model.sv
/*
  Host-side partner: pull-ups on the open-drain pins and a watchdog kick pin.
  Assumes the bench pulses kickReq for one clock whenever the host kicks.
*/
`timescale 1ns/10ps
module rtcwd_host_model (
  input  wire logic clk,
  input  wire logic kickReq,    // One-cycle kick request from the bench
  input  wire logic irqPinOeN,
  input  wire logic irqPinOut,
  input  wire logic rstPinOeN,
  input  wire logic rstPinOut,
  output logic      wdKickIn,   // Toggles on every kick
  output logic      irqLine,    // Resolved interrupt/test wire
  output logic      rstLine     // Resolved reset wire
);
  ////////////////////////////////////////////////////////////////////////////
  // External pull-ups win whenever the device lets go of a pin
  assign irqLine = irqPinOeN ? 1'h1 : irqPinOut;
  assign rstLine = rstPinOeN ? 1'h1 : rstPinOut;

  // A silent host never kicks, so a missed restart is simply no request
  initial wdKickIn = 1'h0;
  always @(posedge clk) begin
    if (kickReq) begin
      wdKickIn <= ~wdKickIn;
    end
  end
endmodule

// file: tb/tb_rtcwd_core.sv
/*
  Self-checking bench: register tasks, pin edge counters and bounded waits.
  Assumes the strobe register port and shortened recovery counts set below.
*/
`timescale 1ns/10ps
module tb_rtcwd_core;
  import rtcwd_pkg::*;
  logic       clk = 1'h0, sys_rst = 1'h1, regWrite = 1'h0, regRead = 1'h0, kickReq = 1'h0;
  logic       supplyOk = 1'h1, fastRstInN = 1'h1, slowRstInN = 1'h1;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, rd;
  logic [1:0] oscCnt = 2'h0;  // One osc cycle per four clocks keeps runs short
  logic       wdKickIn, irqLine, rstLine, irqPinOut, irqPinOeN, rstPinOut, rstPinOeN, sqwPin;
  logic [7:0] addrs [6] = '{OFS_WDOG, OFS_ALMMON, OFS_CONTROL, OFS_SECONDS, OFS_SQWSEL, 8'h10};
  logic [7:0] dflts [6] = '{RST_WDOG, RST_ALMMON, RST_CONTROL, RST_SECONDS, 8'h00, 8'h00};
  int         fails = 0, checked = 0, n;

  ////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  always @(negedge clk) oscCnt <= oscCnt + 2'h1;

  rtcwd_core #(.SLOW_FILT(20), .REC_DEF(20), .REC_SLOW(30), .REC_FAST(10)) dut (
    .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .oscIn(oscCnt[1]), .supplyOk(supplyOk),
    .wdKickIn(wdKickIn), .fastRstInN(fastRstInN), .slowRstInN(slowRstInN), .alarmIrqReq(1'h0),
    .irqPinIn(irqLine), .irqPinOut(irqPinOut), .irqPinOeN(irqPinOeN), .rstPinIn(rstLine),
    .rstPinOut(rstPinOut), .rstPinOeN(rstPinOeN), .sqwPin(sqwPin), .secondTick());

  rtcwd_host_model host (
    .clk(clk), .kickReq(kickReq), .irqPinOeN(irqPinOeN), .irqPinOut(irqPinOut),
    .rstPinOeN(rstPinOeN), .rstPinOut(rstPinOut), .wdKickIn(wdKickIn), .irqLine(irqLine),
    .rstLine(rstLine));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict in one place only
  task automatic stop_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic report(string name, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %0h seen %0h", name, e, g);
    end
  endtask

  task automatic check_byte(string name, logic [7:0] e, logic [7:0] g);
    report(name, {24'h0, e}, {24'h0, g});
  endtask

  task automatic check_bit(string name, logic e, logic g);
    report(name, {31'h0, e}, {31'h0, g});
  endtask

  task automatic check_count(string name, int e, int g);
    report(name, e, g);
  endtask

  // Strobes rise and fall on falling edges, so the taking edge sees them stable
  task automatic reg_write(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrite = 1'h1;
    @(negedge clk);
    regWrite = 1'h0;
  endtask

  task automatic reg_read(logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regRead = 1'h1;
    @(negedge clk);
    regRead = 1'h0;
    @(negedge clk);
    d = regRdData;
  endtask

  function automatic logic pick(int sel);
    return (sel == 0) ? sqwPin : (sel == 1) ? irqLine : rstLine;
  endfunction

  // Bounded wait; running out is a mismatch and ends the run
  task automatic wait_for(int sel, logic v, int bound, string name);
    int k;
    k = 0;
    while (pick(sel) !== v && k < bound) begin
      @(negedge clk);
      k++;
    end
    if (pick(sel) !== v) begin
      check_bit(name, v, pick(sel));
      stop_test();
    end
  endtask

  // Window is a whole number of periods, so the count is exact
  task automatic count_rises(int sel, int win, output int cnt);
    logic prev;
    cnt = 0;
    repeat (3) @(negedge clk);
    prev = pick(sel);
    repeat (win) begin
      @(negedge clk);
      if (prev === 1'h0 && pick(sel) === 1'h1) cnt++;
      prev = pick(sel);
    end
  endtask

  task automatic pulse_rst(bit slow, int k);
    @(negedge clk);
    if (slow) slowRstInN = 1'h0;
    else fastRstInN = 1'h0;
    repeat (k) @(negedge clk);
    slowRstInN = 1'h1;
    fastRstInN = 1'h1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 1'h0;
    @(negedge clk);
    check_bit("power-up reset", 1'h0, rstLine);
    wait_for(2, 1'h1, 100, "power-up release");
    for (int i = 0; i < 6; i++) begin
      reg_read(addrs[i], rd);
      check_byte("default", dflts[i], rd);
    end
    reg_write(OFS_SQWSEL, 8'hA5);
    reg_read(OFS_SQWSEL, rd);
    check_byte("rate readback", 8'hA0, rd);
    // Square wave rates; code 1 follows the oscillator, code 2 is a quarter of it, each higher code halves
    reg_write(OFS_ALMMON, 8'h40);
    for (int c = 0; c < 6; c++) begin
      reg_write(OFS_SQWSEL, 8'(c << 4));
      count_rises(0, 512, n);
      check_count("square wave", (c == 0) ? 0 : (c == 1) ? 128 : (128 >> c), n);
    end
    reg_write(OFS_ALMMON, 8'h00);
    reg_write(OFS_SQWSEL, 8'h10);
    count_rises(0, 512, n);
    check_count("square wave off", 0, n);
    // Watchdog to irq pin: one sixteenth second is 2048 osc cycles
    reg_write(OFS_WDOG, 8'h04);
    repeat (6000) @(negedge clk);
    kickReq = 1'h1;
    @(negedge clk);
    kickReq = 1'h0;
    repeat (8000) @(negedge clk);
    check_bit("irq before period", 1'h1, irqLine);
    wait_for(1, 1'h0, 400, "watchdog irq");
    check_bit("no reset on irq steer", 1'h1, rstLine);
    reg_read(OFS_FLAGS, rd);
    check_byte("flag set", 8'h80, rd);
    reg_read(OFS_FLAGS, rd);
    check_byte("flag cleared", 8'h00, rd);
    reg_write(OFS_WDOG, 8'h00);
    repeat (3) @(negedge clk);
    check_bit("irq released", 1'h1, irqLine);
    // Watchdog to reset pin, then listed bits cleared
    reg_write(OFS_ALMMON, 8'h60);
    reg_write(OFS_CONTROL, 8'hC0);
    reg_write(OFS_WDOG, 8'h84);
    wait_for(2, 1'h0, 8400, "watchdog reset");
    repeat (15) @(negedge clk);
    check_bit("reset pulse held", 1'h0, rstLine);
    wait_for(2, 1'h1, 30, "watchdog reset end");
    for (int i = 0; i < 3; i++) begin
      reg_read(addrs[i], rd);
      check_byte("cleared by reset steer", (i == 2) ? 8'h80 : 8'h00, rd);
    end
    // Test tone at 512 Hz: 256 clocks a period here
    reg_write(OFS_SECONDS, 8'h00);
    reg_write(OFS_CONTROL, 8'hC0);
    count_rises(1, 2048, n);
    check_count("test tone", 8, n);
    reg_write(OFS_WDOG, 8'h04);
    repeat (8400) @(negedge clk);
    count_rises(1, 2048, n);
    check_count("tone under watchdog", 0, n);
    check_bit("watchdog holds pin", 1'h0, irqLine);
    reg_write(OFS_WDOG, 8'h00);
    reg_write(OFS_CONTROL, 8'h00);
    repeat (3) @(negedge clk);
    check_bit("output bit low", 1'h0, irqLine);
    reg_write(OFS_CONTROL, 8'h80);
    repeat (3) @(negedge clk);
    check_bit("output bit high", 1'h1, irqLine);
    // Reset inputs: short pulses ignored, long ones hold the reset pin low through recovery
    pulse_rst(0, 3);
    repeat (10) @(negedge clk);
    check_bit("short fast pulse", 1'h1, rstLine);
    pulse_rst(0, 10);
    check_bit("fast reset", 1'h0, rstLine);
    repeat (20) @(negedge clk);
    check_bit("slow recovery held", 1'h0, rstLine);
    wait_for(2, 1'h1, 40, "fast reset end");
    pulse_rst(1, 10);
    repeat (10) @(negedge clk);
    check_bit("short slow pulse", 1'h1, rstLine);
    pulse_rst(1, 30);
    check_bit("slow reset", 1'h0, rstLine);
    wait_for(2, 1'h1, 50, "slow reset end");
    // Power-down forces reset and clears the test bit
    reg_write(OFS_CONTROL, 8'hC0);
    @(negedge clk);
    supplyOk = 1'h0;
    repeat (5) @(negedge clk);
    check_bit("power-fail reset", 1'h0, rstLine);
    supplyOk = 1'h1;
    wait_for(2, 1'h1, 60, "power return");
    reg_read(OFS_CONTROL, rd);
    check_byte("test bit after power-down", 8'h80, rd);
    stop_test();
  end
endmodule
